/* File: xpm_pkg.sv */
// shared constants and types for the external ram page map
package xpm_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] XPM_PAGE_REG_ADDR = 8'haa;
    localparam logic [7:0] XPM_PAGE_REG_RESET = 8'h00;
    localparam int XPM_PAGE_BIT_POS = 0;

    // ------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------
    localparam int XPM_RAM_BYTES = 512;
    localparam int XPM_IDX_W = 9;
    localparam int XPM_ADDR_W = 16;
    localparam int XPM_DATA_W = 8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic ptr16;
        logic [15:0] addr16;
        logic [7:0] addr8;
        logic [7:0] wdata;
    } xpm_move_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } xpm_sfr_t;

endpackage : xpm_pkg

/* File: xpm_ram.sv */
// single port byte ram with registered read data
`timescale 1ns/1ps
`default_nettype none
module xpm_ram
    import xpm_pkg::*;
#(
    parameter int DEPTH = XPM_RAM_BYTES,
    parameter int IDX_W = XPM_IDX_W
)
(
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [IDX_W-1:0] idx,
    input wire logic [XPM_DATA_W-1:0] wdata,
    output logic [XPM_DATA_W-1:0] rdata_q
);

    // contents are not reset; ram powers up undefined like the real array
    logic [XPM_DATA_W-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            mem_q[idx] <= wdata;
        end
        rdata_q <= mem_q[idx];
    end

endmodule : xpm_ram
`default_nettype wire

/* File: xpm_page_map.sv */
// external ram decode with page select register and flash write redirect
//
// Summary of operation
// - 512-byte ram reachable by external moves
// - 8-bit operand low, page register high
// - pointer moves ignore upper seven address bits for ram, not for flash
// - ram mirrors every 512 bytes across 64k
// - every byte reachable by both addressing modes
// - reads always go to ram; writes go to ram unless flash enabled
// - writes redirect to flash when enabled
`timescale 1ns/1ps
`default_nettype none
module xpm_page_map
    import xpm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire xpm_sfr_t sfr,
    output logic [7:0] sfr_rdata_q,
    input wire logic move_valid,
    input wire xpm_move_t move,
    output logic [7:0] move_rdata_q,
    output logic move_rvalid_q,
    input wire logic flash_write_en,
    output logic flash_wr_q,
    output logic [15:0] flash_addr_q,
    output logic [7:0] flash_wdata_q
);

    // ------------------------------------------------------------
    // address forming
    // ------------------------------------------------------------
    function automatic logic [XPM_IDX_W-1:0] ram_index(
        input logic ptr16,
        input logic [15:0] addr16,
        input logic [7:0] addr8,
        input logic page
    );
        // pointer form keeps low nine bits, so ram repeats per 512 bytes
        if (ptr16)
            return addr16[XPM_IDX_W-1:0];
        else
            return {page, addr8};
    endfunction : ram_index

    logic page_select_bit_q;
    logic page_select_bit_d;
    logic page_hit_wr;
    logic page_hit_rd;
    logic to_flash;
    logic ram_we;
    logic [XPM_IDX_W-1:0] ram_idx;
    logic [15:0] full_addr;
    logic [7:0] sfr_rdata_d;

    assign page_hit_wr = sfr.wr && (sfr.addr == XPM_PAGE_REG_ADDR);
    assign page_hit_rd = sfr.rd && (sfr.addr == XPM_PAGE_REG_ADDR);
    assign page_select_bit_d = page_hit_wr ? sfr.wdata[XPM_PAGE_BIT_POS]
                                           : page_select_bit_q;
    // upper bits are not stored and always read back as zero
    assign sfr_rdata_d = page_hit_rd ? {7'h00, page_select_bit_q}
                                     : 8'h00;

    assign ram_idx = ram_index(move.ptr16, move.addr16, move.addr8,
                               page_select_bit_q);
    assign full_addr = move.ptr16 ? move.addr16
                                  : {7'h00, page_select_bit_q, move.addr8};
    // only writes divert; reads keep coming from ram
    assign to_flash = move_valid && move.we && flash_write_en;
    assign ram_we = move_valid && move.we && !flash_write_en;

    // ------------------------------------------------------------
    // page register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            page_select_bit_q <= XPM_PAGE_REG_RESET[XPM_PAGE_BIT_POS];
            sfr_rdata_q <= 8'h00;
        end
        else
        begin
            page_select_bit_q <= page_select_bit_d;
            sfr_rdata_q <= sfr_rdata_d;
        end
    end

    // ------------------------------------------------------------
    // ram and move return
    // ------------------------------------------------------------
    xpm_ram #(
        .DEPTH(XPM_RAM_BYTES),
        .IDX_W(XPM_IDX_W)
    ) u_ram (
        .clk_sys(clk_sys),
        .we(ram_we),
        .idx(ram_idx),
        .wdata(move.wdata),
        .rdata_q(move_rdata_q)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            move_rvalid_q <= 1'b0;
            flash_wr_q <= 1'b0;
            flash_addr_q <= 16'h0000;
            flash_wdata_q <= 8'h00;
        end
        else
        begin
            move_rvalid_q <= move_valid && !move.we;
            flash_wr_q <= to_flash;
            if (to_flash)
            begin
                // flash sees the full address, not the ram mirror
                flash_addr_q <= full_addr;
                flash_wdata_q <= move.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_page_reset_zero: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        rst |=> (page_select_bit_q == 1'b0))
        else $error("page bit not zero after reset");

    a_page_write_takes: assert property (
        page_hit_wr |=> (page_select_bit_q == $past(sfr.wdata[0])))
        else $error("page bit did not take written value");

    a_page_read_back: assert property (
        page_hit_rd |=> (sfr_rdata_q[7:1] == 7'h00)
            && (sfr_rdata_q[0] == $past(page_select_bit_q)))
        else $error("page register read back wrong");

    a_ptr_index_mod: assert property (
        (move_valid && move.ptr16) |-> (ram_idx == move.addr16[8:0]))
        else $error("pointer move index not modulo 512");

    a_ind_index_page: assert property (
        (move_valid && !move.ptr16)
            |-> (ram_idx == {page_select_bit_q, move.addr8}))
        else $error("indirect move index not page plus operand");

    a_ram_default_wr: assert property (
        (move_valid && move.we && !flash_write_en)
            |-> ram_we ##1 !flash_wr_q)
        else $error("write without flash enable missed ram");

    a_flash_redirect: assert property (
        (move_valid && move.we && flash_write_en)
            |-> !ram_we ##1 flash_wr_q
            && (flash_addr_q == $past(full_addr)))
        else $error("flash write not redirected");

    a_read_returns: assert property (
        (move_valid && !move.we) |=> move_rvalid_q)
        else $error("read had no return strobe");

    a_mirror_data: assert property (
        (move_valid && !move.we && $past(ram_we)
            && ($past(ram_idx) == ram_idx))
            |=> (move_rdata_q == $past(move.wdata, 2)))
        else $error("mirrored byte did not return written data");

    // ------------------------------------------------------------
    // strobe and hold checks
    // ------------------------------------------------------------
    a_no_stray_rvalid: assert property (
        !(move_valid && !move.we) |=> !move_rvalid_q)
        else $error("read strobe without a read");

    a_flash_reads_ram: assert property (
        (move_valid && !move.we && flash_write_en)
            |=> move_rvalid_q && !flash_wr_q)
        else $error("read with flash enabled left ram");

    a_flash_no_pulse: assert property (
        !to_flash |=> !flash_wr_q)
        else $error("flash strobe without a write");

    a_flash_data: assert property (
        to_flash |=> (flash_wdata_q == $past(move.wdata)))
        else $error("flash data not the written byte");

    a_flash_hold: assert property (
        !rst && !to_flash |=> $stable(flash_addr_q) && $stable(flash_wdata_q))
        else $error("flash address or data moved without write");

    a_sfr_idle_zero: assert property (
        !page_hit_rd |=> (sfr_rdata_q == 8'h00))
        else $error("register read data not zero when idle");

    a_page_holds: assert property (
        !rst && !page_hit_wr |=> $stable(page_select_bit_q))
        else $error("page bit changed without a write");

    c_ptr_write: cover property (move_valid && move.we && move.ptr16);
    c_page_one_read: cover property (
        move_valid && !move.we && !move.ptr16 && page_select_bit_q);
    c_flash_write: cover property (to_flash);
    c_mirror_hit: cover property (
        move_valid && move.ptr16 && (move.addr16[15:9] != 7'h00));
    c_back_to_back: cover property (
        move_valid && !move.we && $past(ram_we));

endmodule : xpm_page_map
`default_nettype wire

/* File: xpm_core_model.sv */
// core model issuing external moves and register cycles
`timescale 1ns/1ps
`default_nettype none
module xpm_core_model
    import xpm_pkg::*;
(
    input wire logic clk_sys,
    output logic move_valid,
    output var xpm_move_t move,
    output var xpm_sfr_t sfr
);
    // ----------------------------------------
    // requests
    // ----------------------------------------
    initial
    begin
        move_valid = 1'b0;
        move = '0;
        sfr = '0;
    end
    // released fields flip so a stale value never looks valid
    task automatic move_op(input xpm_move_t m);
    begin
        @(posedge clk_sys);
        move_valid <= 1'b1;
        move <= m;
        @(posedge clk_sys);
        move_valid <= 1'b0;
        move <= ~m;
        #1;
    end
    endtask : move_op
    // two moves on consecutive edges, strobe held up between them
    task automatic move_pair(input xpm_move_t a, input xpm_move_t b);
    begin
        @(posedge clk_sys);
        move_valid <= 1'b1;
        move <= a;
        @(posedge clk_sys);
        move <= b;
        @(posedge clk_sys);
        move_valid <= 1'b0;
        move <= ~b;
        #1;
    end
    endtask : move_pair
    task automatic sfr_op(input xpm_sfr_t s);
    begin
        @(posedge clk_sys);
        sfr <= s;
        @(posedge clk_sys);
        sfr <= '{1'b0, 1'b0, ~s.addr, ~s.wdata};
        #1;
    end
    endtask : sfr_op
endmodule : xpm_core_model
`default_nettype wire

/* File: external_ram_page_address_map_tb.sv */
// self-checking bench for the external ram page map
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module external_ram_page_address_map_tb;
    import xpm_pkg::*;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic flash_write_en = 1'b0;
    logic move_valid, move_rvalid_q, flash_wr_q, page;
    xpm_move_t move;
    xpm_sfr_t sfr;
    logic [7:0] sfr_rdata_q, move_rdata_q, flash_wdata_q;
    logic [15:0] flash_addr_q, fa;
    logic [7:0] mem [0:511];
    int seed = 32'h57d07d34;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int r;
    always #2 clk_sys = ~clk_sys;
    xpm_core_model core (.clk_sys(clk_sys), .move_valid(move_valid),
        .move(move), .sfr(sfr));
    xpm_page_map uut (.clk_sys(clk_sys), .rst(rst), .sfr(sfr),
        .sfr_rdata_q(sfr_rdata_q), .move_valid(move_valid), .move(move),
        .move_rdata_q(move_rdata_q), .move_rvalid_q(move_rvalid_q),
        .flash_write_en(flash_write_en), .flash_wr_q(flash_wr_q),
        .flash_addr_q(flash_addr_q), .flash_wdata_q(flash_wdata_q));
    function automatic logic [15:0] flash_exp(logic p16, logic [15:0] a16,
        logic [7:0] a8);
        return p16 ? a16 : {7'h00, page, a8};
    endfunction : flash_exp
    task automatic give_verdict();
    begin
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask : give_verdict
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    begin
        core.sfr_op('{1'b0, 1'b1, a, 8'h00});
        `CHK(sfr_rdata_q, e)
    end
    endtask : reg_rd
    task automatic reg_wr(input logic [7:0] d);
    begin
        core.sfr_op('{1'b1, 1'b0, XPM_PAGE_REG_ADDR, d});
        page = d[0];
    end
    endtask : reg_wr
    // unused address form carries junk so ignoring it is really tested
    task automatic mv(input logic we, input logic p16, input logic [8:0] ix,
        input logic [7:0] d);
        logic [15:0] a16;
        logic [7:0] a8;
        int h;
    begin
        h = $random(seed);
        if (!p16 && page !== ix[8])
            reg_wr({h[6:0], ix[8]});
        a16 = p16 ? {h[6:0], ix} : {h[6:0], ~ix};
        a8 = p16 ? ~ix[7:0] : ix[7:0];
        fa = flash_exp(p16, a16, a8);
        core.move_op('{we, p16, a16, a8, d});
    end
    endtask : mv
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial
    begin
        page = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        reg_rd(XPM_PAGE_REG_ADDR, XPM_PAGE_REG_RESET);
        reg_wr(8'hfe);
        reg_rd(XPM_PAGE_REG_ADDR, 8'h00);
        reg_wr(8'hff);
        reg_rd(XPM_PAGE_REG_ADDR, 8'h01);
        reg_rd(8'hab, 8'h00);
        for (int i = 0; i < 512; i++)
        begin
            r = $random(seed);
            mem[i] = r[15:8];
            mv(1'b1, r[16], i[8:0], r[15:8]);
            `CHK({move_rvalid_q, flash_wr_q}, 2'b00)
        end
        for (int i = 0; i < 600; i++)
        begin
            r = $random(seed);
            mv(1'b0, r[9], r[8:0], r[17:10]);
            `CHK(move_rvalid_q, 1'b1)
            `CHK(move_rdata_q, mem[r[8:0]])
        end
        // write by pointer, read on the next edge by page and operand
        for (int k = 0; k < 8; k++)
        begin
            r = $random(seed);
            if (page !== r[8])
                reg_wr({7'h00, r[8]});
            core.move_pair('{1'b1, 1'b1, {r[31:25], r[8:0]}, 8'h00, r[16:9]},
                '{1'b0, 1'b0, 16'hffff, r[7:0], 8'h00});
            mem[r[8:0]] = r[16:9];
            `CHK({move_rvalid_q, move_rdata_q}, {1'b1, r[16:9]})
        end
        @(posedge clk_sys);
        flash_write_en <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            mv(1'b1, k[0], 9'h1a5, 8'h3c);
            `CHK({flash_wr_q, flash_wdata_q}, {1'b1, 8'h3c})
            `CHK(flash_addr_q, fa)
            mv(1'b0, k[0], 9'h1a5, 8'h00);
            `CHK(move_rdata_q, mem[9'h1a5])
        end
        reg_wr(8'h01);
        @(posedge clk_sys);
        flash_write_en <= 1'b0;
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        reg_rd(XPM_PAGE_REG_ADDR, 8'h00);
        give_verdict();
    end
endmodule : external_ram_page_address_map_tb
`undef CHK
`default_nettype wire
